// ===== common/rsp_pkg.sv
// rsp_pkg: constants for the reset status and peripheral enable block
`default_nettype none
package rsp_pkg;

   // ----------------------------------------------------------------------
   // bus widths
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 32;                    // byte address width
   localparam int DATA_W = 32;                    // register data width
   localparam int NUM_SRC = 7;                    // maskable reset sources

   // ----------------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------------
   localparam logic [31:0] ADDR_SOFT_CTRL    = 32'h4000_0008;
   localparam logic [31:0] ADDR_SRC_ENABLE   = 32'h4000_0018;
   localparam logic [31:0] ADDR_CAUSE_STATUS = 32'h4000_001C;
   localparam logic [31:0] ADDR_ACCEPT_1     = 32'h4000_0020;
   localparam logic [31:0] ADDR_ACCEPT_2     = 32'h4000_0024;
   localparam logic [31:0] ADDR_RUN_EN_1     = 32'h4000_0028;
   localparam logic [31:0] ADDR_RUN_EN_2     = 32'h4000_002C;
   localparam logic [31:0] ADDR_IRQ_STATUS   = 32'h4000_0060;
   localparam logic [31:0] ADDR_IRQ_ENABLE   = 32'h4000_0064;
   localparam logic [31:0] ADDR_IRQ_CLEAR    = 32'h4000_0068;

   // ----------------------------------------------------------------------
   // reset cause status bits
   // ----------------------------------------------------------------------
   localparam int BIT_POWER_ON   = 7;
   localparam int BIT_PIN        = 6;
   localparam int BIT_CPU        = 5;
   localparam int BIT_SOFT       = 4;
   localparam int BIT_WATCHDOG   = 3;
   localparam int BIT_MCLK_FAIL  = 2;
   localparam int BIT_XOSC_FAIL  = 1;
   localparam int BIT_LOW_VOLT   = 0;
   localparam int BIT_SOFT_CTRL  = 1;             // soft reset trigger bit

   // ----------------------------------------------------------------------
   // reset values and writable masks
   // ----------------------------------------------------------------------
   localparam logic [7:0]  CAUSE_RST     = 8'h80;
   localparam logic [6:0]  SRC_EN_RST    = 7'h49;
   localparam logic [31:0] RUN_EN_1_MASK = 32'h030F_0F10;
   localparam logic [31:0] ACCEPT_1_MASK = 32'h030F_0F1F;
   localparam logic [31:0] GROUP_2_MASK  = 32'h0031_0311;
   localparam logic [31:0] RUN_EN_RST    = 32'h0000_0000;
   localparam logic [31:0] ACCEPT_1_RST  = ACCEPT_1_MASK;
   localparam logic [31:0] ACCEPT_2_RST  = GROUP_2_MASK;

   // ----------------------------------------------------------------------
   // system-level bits of the first accept register
   // ----------------------------------------------------------------------
   localparam int BIT_SYS_CTRL   = 0;             // system_control_unit
   localparam int BIT_FLASH      = 1;             // flash_controller_unit
   localparam int BIT_WDOG_UNIT  = 2;             // watchdog_unit
   localparam int BIT_PORT_CTRL  = 3;             // port_control_unit

   // ----------------------------------------------------------------------
   // interrupt status bits
   // ----------------------------------------------------------------------
   localparam int IRQ_W          = 2;
   localparam int IRQ_RESET_DONE = 0;             // event reset applied
   localparam int IRQ_MASKED     = 1;             // masked source seen

   // ----------------------------------------------------------------------
   // event reset length
   // ----------------------------------------------------------------------
   localparam int EVT_RST_CYCLES = 4;

endpackage : rsp_pkg
`default_nettype wire

// ===== hw/rsp_stretch.sv
// rsp_stretch: holds a one-cycle start pulse high for a fixed count
`timescale 1ns/100ps
`default_nettype none
module rsp_stretch
#(
   parameter int CYCLES = 4                       // length of the stretch
)
(
   input  wire logic ref_clk,                     // system clock
   input  wire logic rst,                         // sync reset, active high
   input  wire logic start,                       // one-cycle trigger
   output var  logic active                       // high for CYCLES cycles
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed
   {
      logic       act;                            // stretch in progress
      logic [7:0] cnt;                            // cycles left
   } rsp_str_t;

   rsp_str_t s_r;                                 // registered state
   rsp_str_t s_nxt;                               // next state

   // refuse lengths the 8-bit counter cannot hold
   if (CYCLES < 1 || CYCLES > 255)
   begin : g_bad
      $error("rsp_stretch: CYCLES out of range");
   end

   // ----------------------------------------------------------------------
   // next state: a new start restarts the full count
   // ----------------------------------------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      if (start)
      begin
         s_nxt.act = 1'b1;
         s_nxt.cnt = 8'(CYCLES - 1);
      end
      else if (s_r.act)
      begin
         if (s_r.cnt == 8'h00)
            s_nxt.act = 1'b0;
         else
            s_nxt.cnt = s_r.cnt - 8'h01;
      end
   end

   // register the state
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign active = s_r.act;

endmodule : rsp_stretch
`default_nettype wire

// ===== hw/rsp_top.sv
// rsp_top: reset cause status, event reset masks and peripheral enables
`timescale 1ns/100ps
`default_nettype none
module rsp_top
   import rsp_pkg::*;
#(
   parameter int EVENT_RESET_CYCLES = rsp_pkg::EVT_RST_CYCLES
)
(
   input  wire logic                       ref_clk,    // 20 MHz clock
   input  wire logic                       rst,        // power-on reset
   input  wire logic [rsp_pkg::ADDR_W-1:0] reg_addr,   // byte address
   input  wire logic [rsp_pkg::DATA_W-1:0] reg_wdata,  // write data
   input  wire logic                       reg_wr,     // write strobe
   input  wire logic                       reg_rd,     // read strobe
   output var  logic [rsp_pkg::DATA_W-1:0] reg_rdata,  // read data
   input  wire logic [rsp_pkg::NUM_SRC-1:0] src_event, // reset source pulses
   output var  logic                       event_reset,// to reset generator
   output var  logic [31:0]                periph_rst_1,// group 1 resets
   output var  logic [31:0]                periph_rst_2,// group 2 resets
   output var  logic                       irq         // level interrupt
);
   import rsp_pkg::*;

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed
   {
      logic [7:0]         cause;                  // reset cause flags
      logic [6:0]         src_en;                 // source enable mask
      logic               soft_req;               // soft reset, self-clear
      logic [31:0]        accept_1;               // event reset accept 1
      logic [31:0]        accept_2;               // event reset accept 2
      logic [31:0]        run_en_1;               // peripheral enable 1
      logic [31:0]        run_en_2;               // peripheral enable 2
      logic [IRQ_W-1:0]   irq_st;                 // sticky irq status
      logic [IRQ_W-1:0]   irq_en;                 // irq enable
      logic               irq;                    // interrupt output
      logic [31:0]        rdata;                  // read data
      logic [31:0]        prst_1;                 // group 1 reset out
      logic [31:0]        prst_2;                 // group 2 reset out
      logic               evt_rst;                // event reset out
   } rsp_state_t;

   rsp_state_t s_r;                               // registered state
   rsp_state_t s_nxt;                             // next state

   logic             evt_active;                  // stretched event reset
   logic [6:0]       raw_src;                     // all source pulses
   logic [6:0]       pass_src;                    // enabled sources
   logic [6:0]       masked_src;                  // suppressed sources
   logic             fire;                        // an event reset starts

   // refuse an event reset length the stretcher cannot serve
   if (EVENT_RESET_CYCLES < 1 || EVENT_RESET_CYCLES > 255)
   begin : g_bad
      $error("rsp_top: EVENT_RESET_CYCLES out of range");
   end

   // ----------------------------------------------------------------------
   // source qualification
   // ----------------------------------------------------------------------
   // the soft reset request joins the software source line
   always_comb
   begin
      raw_src = src_event;
      raw_src[BIT_SOFT] = src_event[BIT_SOFT] | s_r.soft_req;
      pass_src = raw_src & s_r.src_en;
      masked_src = raw_src & ~s_r.src_en;
      fire = |pass_src;
   end

   // ----------------------------------------------------------------------
   // event reset length
   // ----------------------------------------------------------------------
   // a fresh event during a running reset restarts the count
   rsp_stretch #(
      .CYCLES (EVENT_RESET_CYCLES)
   ) u_stretch (
      .ref_clk (ref_clk),
      .rst     (rst),
      .start   (fire),
      .active  (evt_active)
   );

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.soft_req = 1'b0;                      // self-clearing trigger

      // register writes
      if (reg_wr)
      begin
         if (reg_addr == ADDR_SOFT_CTRL)
         begin
            s_nxt.soft_req = reg_wdata[BIT_SOFT_CTRL];
         end
         else if (reg_addr == ADDR_SRC_ENABLE)
         begin
            s_nxt.src_en = reg_wdata[6:0];
         end
         else if (reg_addr == ADDR_CAUSE_STATUS)
         begin
            // only the bits written as one are cleared
            s_nxt.cause = s_r.cause & ~reg_wdata[7:0];
         end
         else if (reg_addr == ADDR_ACCEPT_1)
         begin
            s_nxt.accept_1 = reg_wdata & ACCEPT_1_MASK;
         end
         else if (reg_addr == ADDR_ACCEPT_2)
         begin
            s_nxt.accept_2 = reg_wdata & GROUP_2_MASK;
         end
         else if (reg_addr == ADDR_RUN_EN_1)
         begin
            s_nxt.run_en_1 = reg_wdata & RUN_EN_1_MASK;
         end
         else if (reg_addr == ADDR_RUN_EN_2)
         begin
            s_nxt.run_en_2 = reg_wdata & GROUP_2_MASK;
         end
         else if (reg_addr == ADDR_IRQ_ENABLE)
         begin
            s_nxt.irq_en = reg_wdata[IRQ_W-1:0];
         end
         else if (reg_addr == ADDR_IRQ_CLEAR)
         begin
            s_nxt.irq_st = s_r.irq_st & ~reg_wdata[IRQ_W-1:0];
         end
         else
         begin
            // unmapped address: write is dropped
            s_nxt.rdata = s_r.rdata;
         end
      end

      // cause flags: a new event beats a clear in the same cycle, and
      // the flags are not touched by the event reset itself
      s_nxt.cause[6:0] = s_nxt.cause[6:0] | pass_src;

      // interrupt events, set wins over clear
      if (fire)
         s_nxt.irq_st[IRQ_RESET_DONE] = 1'b1;
      if (|masked_src)
         s_nxt.irq_st[IRQ_MASKED] = 1'b1;

      // an accepted event reset of the system control part brings the
      // control registers back to their defaults; the cause flags stay
      if (fire && s_r.accept_1[BIT_SYS_CTRL])
      begin
         s_nxt.src_en   = SRC_EN_RST;
         s_nxt.accept_1 = ACCEPT_1_RST;
         s_nxt.accept_2 = ACCEPT_2_RST;
         s_nxt.run_en_1 = RUN_EN_RST;
         s_nxt.run_en_2 = RUN_EN_RST;
         s_nxt.irq_en   = '0;
      end

      // peripheral resets: held while disabled, and pulsed by an event
      // reset only where the peripheral accepts it
      s_nxt.prst_1 = (~s_r.run_en_1 & RUN_EN_1_MASK)
                   | (evt_active ? s_r.accept_1 : 32'h0000_0000);
      s_nxt.prst_2 = (~s_r.run_en_2 & GROUP_2_MASK)
                   | (evt_active ? s_r.accept_2 : 32'h0000_0000);
      s_nxt.evt_rst = evt_active;

      // level interrupt from the enabled sticky bits
      s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_en);

      // read data, valid in the cycle after the strobe only
      s_nxt.rdata = 32'h0000_0000;
      if (reg_rd)
      begin
         if (reg_addr == ADDR_SOFT_CTRL)
         begin
            s_nxt.rdata[BIT_SOFT_CTRL] = s_r.soft_req;
         end
         else if (reg_addr == ADDR_SRC_ENABLE)
         begin
            s_nxt.rdata[6:0] = s_r.src_en;
         end
         else if (reg_addr == ADDR_CAUSE_STATUS)
         begin
            s_nxt.rdata[7:0] = s_r.cause;
         end
         else if (reg_addr == ADDR_ACCEPT_1)
         begin
            s_nxt.rdata = s_r.accept_1;
         end
         else if (reg_addr == ADDR_ACCEPT_2)
         begin
            s_nxt.rdata = s_r.accept_2;
         end
         else if (reg_addr == ADDR_RUN_EN_1)
         begin
            s_nxt.rdata = s_r.run_en_1;
         end
         else if (reg_addr == ADDR_RUN_EN_2)
         begin
            s_nxt.rdata = s_r.run_en_2;
         end
         else if (reg_addr == ADDR_IRQ_STATUS)
         begin
            s_nxt.rdata[IRQ_W-1:0] = s_r.irq_st;
         end
         else if (reg_addr == ADDR_IRQ_ENABLE)
         begin
            s_nxt.rdata[IRQ_W-1:0] = s_r.irq_en;
         end
         else
         begin
            // unmapped and write-only addresses read zero
            s_nxt.rdata = 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   // power-on reset: only the power-on flag is left standing, and every
   // peripheral is held in reset until software enables it
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         s_r          <= '0;
         s_r.cause    <= CAUSE_RST;
         s_r.src_en   <= SRC_EN_RST;
         s_r.accept_1 <= ACCEPT_1_RST;
         s_r.accept_2 <= ACCEPT_2_RST;
         s_r.run_en_1 <= RUN_EN_RST;
         s_r.run_en_2 <= RUN_EN_RST;
         s_r.prst_1   <= RUN_EN_1_MASK;
         s_r.prst_2   <= GROUP_2_MASK;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // outputs, all straight from the state register
   // ----------------------------------------------------------------------
   assign reg_rdata    = s_r.rdata;
   assign event_reset  = s_r.evt_rst;
   assign periph_rst_1 = s_r.prst_1;
   assign periph_rst_2 = s_r.prst_2;
   assign irq          = s_r.irq;

endmodule : rsp_top
`default_nettype wire

// ===== test/rsp_top_properties.sv
// rsp_top_properties: port-level assertions for the reset status block
`timescale 1ns/100ps
`default_nettype none
module rsp_top_properties
   import rsp_pkg::*;
#(
   parameter int EVENT_RESET_CYCLES = 4          // repetitions assume 4
)
(
   input wire logic                        ref_clk,
   input wire logic                        rst,
   input wire logic [rsp_pkg::ADDR_W-1:0]  reg_addr,
   input wire logic [rsp_pkg::DATA_W-1:0]  reg_wdata,
   input wire logic                        reg_wr,
   input wire logic                        reg_rd,
   input wire logic [rsp_pkg::DATA_W-1:0]  reg_rdata,
   input wire logic [rsp_pkg::NUM_SRC-1:0] src_event,
   input wire logic                        event_reset,
   input wire logic [31:0]                 periph_rst_1,
   input wire logic [31:0]                 periph_rst_2,
   input wire logic                        irq
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // -------------------------------------------------------------------
   // register port
   // -------------------------------------------------------------------
   // read data only stands in the cycle after a read strobe
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
      else $error("read data not zero outside a read");
   // unused bits of the first accept register must never read back as set
   accept_bits_a: assert property (reg_rd && reg_addr == ADDR_ACCEPT_1
      |=> (reg_rdata & ~ACCEPT_1_MASK) == '0)
      else $error("accept register shows bits outside its layout");
   // -------------------------------------------------------------------
   // reset and peripheral hold
   // -------------------------------------------------------------------
   reset_out_a: assert property ($fell(rst) |->
      periph_rst_1 == RUN_EN_1_MASK && periph_rst_2 == GROUP_2_MASK
      && !event_reset && !irq)
      else $error("outputs wrong when reset ends");
   // a disabled enable bit reaches the reset output two cycles on
   run_enable_a: assert property (reg_wr && reg_addr == ADDR_RUN_EN_1
      |=> ##1 (event_reset
      || periph_rst_1 == (~$past(reg_wdata, 2) & RUN_EN_1_MASK)))
      else $error("group 1 reset does not follow enable write");
   grp1_idle_a: assert property (!event_reset |->
      (periph_rst_1 & ~RUN_EN_1_MASK) == '0)
      else $error("group 1 reset on a reserved bit");
   grp2_bits_a: assert property (
      (periph_rst_2 & ~GROUP_2_MASK) == '0)
      else $error("group 2 reset on a reserved bit");
   // -------------------------------------------------------------------
   // event reset
   // -------------------------------------------------------------------
   evt_length_a: assert property ($rose(event_reset) |->
      event_reset[*4])
      else $error("event reset shorter than its length");
   evt_end_a: assert property ($fell(event_reset) |->
      $past(event_reset, 4))
      else $error("event reset ended early");
   // only a source pulse or a soft reset write can start one
   evt_cause_a: assert property ($rose(event_reset) |->
      $past(src_event, 2) != '0 || ($past(reg_wr, 3)
      && $past(reg_addr, 3) == ADDR_SOFT_CTRL))
      else $error("event reset without a cause");
   evt_cov_c: cover property ($rose(event_reset));
   irq_cov_c: cover property ($rose(irq));
   soft_cov_c: cover property (reg_wr && reg_addr == ADDR_SOFT_CTRL);
endmodule : rsp_top_properties
bind rsp_top rsp_top_properties
   #(.EVENT_RESET_CYCLES(EVENT_RESET_CYCLES)) u_props
   (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .src_event(src_event),
    .event_reset(event_reset), .periph_rst_1(periph_rst_1),
    .periph_rst_2(periph_rst_2), .irq(irq));
`default_nettype wire

// ===== test/tb_rsp_top.sv
// tb_rsp_top: directed register and event reset tests for rsp_top
`timescale 1ns/100ps
`default_nettype none
module tb_rsp_top;
   import rsp_pkg::*;
   logic        ref_clk, rst, reg_wr, reg_rd, event_reset, irq;
   logic [31:0] reg_addr, reg_wdata, reg_rdata, periph_rst_1, periph_rst_2;
   logic [6:0]  src_event;                       // reset source pulses
   logic [7:0]  cause_exp;                       // expected cause flags
   int          n_fail, comparisons, cycles;
   rsp_top #(.EVENT_RESET_CYCLES(4)) dut
   (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .src_event(src_event),
    .event_reset(event_reset), .periph_rst_1(periph_rst_1),
    .periph_rst_2(periph_rst_2), .irq(irq));
   // -------------------------------------------------------------------
   // clock, watchdog on hangs
   // -------------------------------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // the tests need under 200 cycles; the ceiling leaves wide margin
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_fail++;
         $display("mismatch at %0t: run timed out", $time);
         finish_test();
      end
   end
   // -------------------------------------------------------------------
   // tasks
   // -------------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check
   // every bus task starts at an edge, so strobes never change twice
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask : wr
   // data is looked at only in the single cycle it stands
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      @(negedge ref_clk);
      check(reg_rdata, exp, "read data");
   endtask : rd
   task automatic pulse(input logic [6:0] ev);
      @(posedge ref_clk);
      src_event <= ev;
      @(posedge ref_clk);
      src_event <= 7'h00;
   endtask : pulse
   // let n edges land, then sample mid-cycle
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : settle
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test
   // -------------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------------
   initial
   begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 32'h0;
      reg_wdata = 32'h0;
      src_event = 7'h00;
      n_fail = 0;
      comparisons = 0;
      cycles = 0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      // reset values, unmapped read
      rd(ADDR_CAUSE_STATUS, 32'h0000_0080);
      rd(ADDR_ACCEPT_1, 32'h030F_0F1F);
      rd(ADDR_ACCEPT_2, 32'h0031_0311);
      rd(ADDR_RUN_EN_1, 32'h0000_0000);
      rd(ADDR_SRC_ENABLE, 32'h0000_0049);
      rd(32'h4000_0050, 32'h0000_0000);
      check(periph_rst_1, 32'h030F_0F10, "group 1 held");
      check(periph_rst_2, 32'h0031_0311, "group 2 held");
      $display("test reset values done");
      // enables: reserved bits read zero, clearing one resets the unit
      wr(ADDR_RUN_EN_1, 32'hFFFF_FFFF);
      rd(ADDR_RUN_EN_1, 32'h030F_0F10);
      wr(ADDR_RUN_EN_2, 32'hFFFF_FFFF);
      rd(ADDR_RUN_EN_2, 32'h0031_0311);
      check(periph_rst_2, 32'h0, "group 2 released");
      wr(ADDR_RUN_EN_1, 32'h030F_0F00);
      settle(1);
      check(periph_rst_1, 32'h0000_0010, "dma held");
      $display("test run enables done");
      // only accepting units see an event; flags survive it
      wr(ADDR_ACCEPT_1, 32'hFFFF_FFFF);
      rd(ADDR_ACCEPT_1, 32'h030F_0F1F);
      wr(ADDR_ACCEPT_1, 32'h0100_0000);
      wr(ADDR_ACCEPT_2, 32'h0010_0000);
      pulse(7'h08);
      settle(2);
      check(32'(event_reset), 32'h1, "event reset");
      check(periph_rst_1, 32'h0100_0010, "group 1 event");
      check(periph_rst_2, 32'h0010_0000, "group 2 event");
      settle(4);
      check(32'(event_reset), 32'h0, "event over");
      check(periph_rst_1, 32'h0000_0010, "group 1 after");
      rd(ADDR_CAUSE_STATUS, 32'h0000_0088);
      // interrupt raised, enabled, cleared
      rd(ADDR_IRQ_STATUS, 32'h0000_0001);
      wr(ADDR_IRQ_ENABLE, 32'h0000_0003);
      settle(2);
      check(32'(irq), 32'h1, "irq raised");
      wr(ADDR_IRQ_CLEAR, 32'h0000_0001);
      settle(2);
      check(32'(irq), 32'h0, "irq cleared");
      // write one clears only the flags written
      wr(ADDR_CAUSE_STATUS, 32'h0000_0008);
      rd(ADDR_CAUSE_STATUS, 32'h0000_0080);
      wr(ADDR_CAUSE_STATUS, 32'h0000_0080);
      rd(ADDR_CAUSE_STATUS, 32'h0000_0000);
      $display("test accept masks done");
      // a masked source gives no reset and no cause flag, only the masked irq flag
      pulse(7'h20);
      settle(3);
      check(32'(event_reset), 32'h0, "masked source");
      rd(ADDR_CAUSE_STATUS, 32'h0000_0000);
      rd(ADDR_IRQ_STATUS, 32'h0000_0002);
      check(32'(irq), 32'h1, "irq masked seen");
      wr(ADDR_IRQ_CLEAR, 32'h0000_0002);
      $display("test masked source done");
      // every source in turn sets its own flag
      wr(ADDR_SRC_ENABLE, 32'h0000_007F);
      cause_exp = 8'h00;
      for (int i = 0; i < 7; i++)
      begin
         pulse(7'(1 << i));
         cause_exp[i] = 1'b1;
         settle(6);
         rd(ADDR_CAUSE_STATUS, {24'h0, cause_exp});
      end
      $display("test all sources done");
      // soft reset request applies a reset and clears itself
      wr(ADDR_CAUSE_STATUS, 32'h0000_00FF);
      wr(ADDR_SOFT_CTRL, 32'h0000_0002);
      // request flop, then stretcher, then output flop: two edges on
      settle(2);
      check(32'(event_reset), 32'h1, "soft reset");
      rd(ADDR_SOFT_CTRL, 32'h0000_0000);
      settle(4);
      rd(ADDR_CAUSE_STATUS, 32'h0000_0010);
      $display("test soft reset done");
      // system unit accepting: an event restores the settings
      wr(ADDR_ACCEPT_1, 32'h030F_0F1F);
      pulse(7'h01);
      settle(6);
      rd(ADDR_SRC_ENABLE, 32'h0000_0049);
      rd(ADDR_RUN_EN_1, 32'h0000_0000);
      $display("test system restore done");
      finish_test();
   end
endmodule : tb_rsp_top
`default_nettype wire
